// file: core/csd_pkg.sv
// Package of constants and types for the chip-select decoder
package csd_pkg;
   // ****************************************
   // Register map (byte addr, word index = addr/4)
   // ****************************************
   localparam logic [7:0] ADDR_PIN_ASSIGN0 = 8'h00;
   localparam logic [7:0] ADDR_PIN_ASSIGN1 = 8'h04;
   localparam logic [7:0] ADDR_DISCRETE = 8'h08;
   localparam logic [7:0] ADDR_BOOT_BASE = 8'h0C;
   localparam logic [7:0] ADDR_BOOT_OPTION = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_CH_BASE0 = 8'h40;
   localparam logic [7:0] ADDR_CH_OPTION0 = 8'h80;
   localparam int NUM_GENERAL = 11;
   localparam int NUM_PINS = 12;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int BASE_BLOCK_SIZE_CODE_LSB = 0;
   localparam int BASE_ADDR_LSB = 3;
   localparam int OPT_IPL_LSB = 1;
   localparam int OPT_SPACE_LSB = 4;
   localparam int OPT_RW_LSB = 11;
   localparam int OPT_BYTE_LSB = 13;
   localparam int OPT_MODE_BIT = 15;
   localparam int OPT_AUTOVECTOR_REQUEST_BIT = 0;
   localparam int OPT_SIZE_ACK_LSB = 6;
   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [15:0] BOOT_BASE_RESET = 16'h0006;
   localparam logic [15:0] BOOT_OPTION_RESET = 16'h6830;
   localparam logic [15:0] CH_BASE_RESET = 16'h0000;
   localparam logic [15:0] CH_OPTION_RESET = 16'h0000;
   localparam logic [1:0] BYTE_BOTH = 2'h3;
   localparam logic [23:0] PIN_ASSIGN_RESET = 24'h000000;
   localparam logic [6:0] DISCRETE_RESET = 7'h00;
   // ****************************************
   // Encodings
   // ****************************************
   typedef enum logic [1:0] {
      CSD_PIN_DISCRETE = 2'h0,
      CSD_PIN_ALTERNATE = 2'h1,
      CSD_PIN_SELECT8 = 2'h2,
      CSD_PIN_SELECT16 = 2'h3
   } csd_pin_type;
   localparam logic [1:0] SPACE_CPU = 2'h0;
   localparam logic [1:0] SPACE_USER = 2'h1;
   localparam logic [1:0] SPACE_SUPV = 2'h2;
   localparam logic [1:0] RW_READ = 2'h1;
   localparam logic [1:0] RW_WRITE = 2'h2;
   localparam logic [3:0] SIZE_ACK_FAST = 4'hE;
   localparam logic [3:0] SIZE_ACK_EXTERNAL = 4'hF;
   localparam logic [2:0] FC_CPU_SPACE = 3'h7;
   localparam logic [3:0] SPACE_TYPE_IACK = 4'hF;
endpackage

// file: core/csd_channel.sv
// One chip-select channel compare unit
`timescale 1ns/1ps
module csd_channel (
   input wire logic [15:0] i_base,
   input wire logic [15:0] i_option,
   input wire logic i_wide_port,
   input wire logic [23:0] i_addr,
   input wire logic [2:0] i_fc,
   input wire logic i_read,
   input wire logic [1:0] i_siz,
   output logic o_match
);
   logic [2:0] blk;
   logic [12:0] base_hi;
   logic [12:0] mask;
   logic [1:0] space;
   logic [1:0] rw;
   logic [1:0] byte_f;
   logic [2:0] ack_priority_level;
   logic cpu_space;
   logic space_ok;
   logic rw_ok;
   logic byte_ok;
   logic ipl_ok;
   logic addr_ok;
   logic upper;
   logic lower;

   // Mask of compared bits 23:11 per block size
   function automatic logic [12:0] blk_mask(input logic [2:0] code);
      case (code)
         3'h0: blk_mask = 13'h1FFF;
         3'h1: blk_mask = 13'h1FFC;
         3'h2: blk_mask = 13'h1FF8;
         3'h3: blk_mask = 13'h1FE0;
         3'h4: blk_mask = 13'h1FC0;
         3'h5: blk_mask = 13'h1F80;
         3'h6: blk_mask = 13'h1F00;
         default: blk_mask = 13'h1E00;
      endcase
   endfunction

   always_comb begin
      blk = i_base[csd_pkg::BASE_BLOCK_SIZE_CODE_LSB +: 3];
      base_hi = i_base[csd_pkg::BASE_ADDR_LSB +: 13];
      mask = blk_mask(blk);
      space = i_option[csd_pkg::OPT_SPACE_LSB +: 2];
      rw = i_option[csd_pkg::OPT_RW_LSB +: 2];
      byte_f = i_option[csd_pkg::OPT_BYTE_LSB +: 2];
      ack_priority_level = i_option[csd_pkg::OPT_IPL_LSB +: 3];
      cpu_space = (i_fc == csd_pkg::FC_CPU_SPACE);
      addr_ok = ((i_addr[23:11] ^ base_hi) & mask) == 13'h0000;
      case (space)
         csd_pkg::SPACE_CPU: space_ok = cpu_space;
         csd_pkg::SPACE_USER: space_ok = !cpu_space && !i_fc[2];
         csd_pkg::SPACE_SUPV: space_ok = !cpu_space && i_fc[2];
         default: space_ok = !cpu_space;
      endcase
      // Priority compared only for CPU-space cycles (function code 7)
      ipl_ok = !cpu_space || (ack_priority_level == 3'h0) || (ack_priority_level == i_addr[3:1]);
      case (rw)
         csd_pkg::RW_READ: rw_ok = i_read;
         csd_pkg::RW_WRITE: rw_ok = !i_read;
         2'h3: rw_ok = 1'b1;
         default: rw_ok = 1'b0;
      endcase
      // Upper byte lane is the even address; word access hits both
      upper = !i_addr[0];
      lower = i_addr[0] || (i_siz != 2'h1);
      if (!i_wide_port) begin
         byte_ok = (byte_f != 2'h0);
      end else begin
         byte_ok = (byte_f[1] && upper) || (byte_f[0] && lower);
      end
      o_match = addr_ok && space_ok && ipl_ok && rw_ok && byte_ok;
   end
endmodule // csd_channel

// file: core/csd_decoder.sv
// Chip-select decoder top with Wishbone register file
//
// Our own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
// Function
// - Select only when all access parameters match
// - Select outputs are active low
// - Internal address hits suppress select, external bus
// - General channels disabled until byte field nonzero
// - Boot select active straight out of reset
// - Twelve two-bit pin fields in two registers
// - Pin codes: discrete, alternate, 8-bit, 16-bit
// - Pins 1-3 ignore code 00; boot pin 0 still selects on it
// - Discrete pins drive latch bits, selects 3-9
// - Pin 11 discrete code drives bus clock
// - Reset straps pick 16-bit or alternate for pins 1-11
// - Data line zero picks boot port width
// - Compare runs for discrete/alternate pins too
// - Block size picks compared upper address bits
// - Overlapping channels each assert own select
// - Boot base zero, block 512K at reset
// - Internal size ack and autovector per channel
// - Narrow port: nonzero byte field enables; boot 11
// - Async select with strobe; sync with clock
// - Wide port checks addr bit 0 and size
module csd_decoder #(
   parameter int NUM_GENERAL = 11
) (
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   input wire logic [7:0] i_strap_data,
   input wire logic [23:0] i_addr,
   input wire logic [2:0] i_fc,
   input wire logic i_read,
   input wire logic [1:0] i_transfer_size_lines,
   input wire logic i_addr_strobe,
   input wire logic i_data_strobe,
   input wire logic i_sync_bus_clock,
   input wire logic i_internal_hit,
   output logic o_ext_bus_enable,
   output logic [NUM_GENERAL:0] o_select_n,
   output logic [NUM_GENERAL:0] o_pin_value,
   output logic [NUM_GENERAL:0] o_pin_is_alternate,
   output logic o_size_ack_n,
   output logic o_autovector_request_n
);
   localparam int NCH = NUM_GENERAL + 1;
   // ****************************************
   // Registers
   // ****************************************
   logic [23:0] pin_assignment_regs;
   logic [6:0] discrete_output_latch;
   logic [15:0] boot_base_reg;
   logic [15:0] boot_option_reg;
   logic [15:0] channel_base_regs [NUM_GENERAL];
   logic [15:0] channel_option_regs [NUM_GENERAL];
   logic strap_pending;
   logic ack;
   logic [31:0] rdata;
   logic [23:0] next_pin;
   logic [6:0] next_discrete;
   logic [15:0] next_boot_base;
   logic [15:0] next_boot_option;
   logic [15:0] next_base [NUM_GENERAL];
   logic [15:0] next_option [NUM_GENERAL];
   logic next_ack;
   logic [31:0] next_rdata;
   logic wr;
   logic [15:0] wdata;
   logic [NCH-1:0] match;
   logic [NCH-1:0] sel_q;
   logic [NCH-1:0] next_sel;
   logic [NCH-1:0] pin_q;
   logic [NCH-1:0] next_pin_val;
   logic ack_q;
   logic autovector_request_q;
   logic next_ack_out;
   logic next_autovector_request;
   logic [15:0] opt [NCH];
   logic [15:0] bas [NCH];

   // Strap data pin feeding each pin field; boot is not strapped here
   function automatic int strap_bit(input int ch);
      case (ch)
         0: strap_bit = 1;
         1, 2: strap_bit = 2;
         3, 4, 5: strap_bit = 3;
         6: strap_bit = 4;
         7: strap_bit = 5;
         8: strap_bit = 6;
         default: strap_bit = 7;
      endcase
   endfunction

   // Pins with no discrete function
   function automatic logic no_discrete(input int ch);
      no_discrete = (ch <= 3);
   endfunction

   // ****************************************
   // Register file over Wishbone
   // ****************************************
   assign wr = i_wb_cyc && i_wb_stb && i_wb_we && !ack;
   assign wdata = {i_wb_sel[1] ? i_wb_dat[15:8] : 8'h00, i_wb_sel[0] ? i_wb_dat[7:0] : 8'h00};

   always_comb begin
      next_pin = pin_assignment_regs;
      next_discrete = discrete_output_latch;
      next_boot_base = boot_base_reg;
      next_boot_option = boot_option_reg;
      next_base = channel_base_regs;
      next_option = channel_option_regs;
      next_ack = i_wb_cyc && i_wb_stb && !ack;
      next_rdata = 32'h00000000;
      if (strap_pending) begin
         // Straps caught on the first edge after release
         next_boot_option[csd_pkg::OPT_BYTE_LSB +: 2] = csd_pkg::BYTE_BOTH;
         next_pin[1:0] = i_strap_data[0] ? 2'h3 : 2'h2;
         for (int c = 0; c < NUM_GENERAL; c++) begin
            next_pin[2*(c+1) +: 2] = i_strap_data[strap_bit(c)] ? 2'h3 : 2'h1;
         end
      end else if (wr) begin
         case (i_wb_adr)
            csd_pkg::ADDR_PIN_ASSIGN0: next_pin[11:0] = wdata[11:0];
            csd_pkg::ADDR_PIN_ASSIGN1: next_pin[23:12] = wdata[11:0];
            csd_pkg::ADDR_DISCRETE: next_discrete = wdata[6:0];
            csd_pkg::ADDR_BOOT_BASE: next_boot_base = wdata;
            csd_pkg::ADDR_BOOT_OPTION: next_boot_option = wdata;
            default: begin
               for (int c = 0; c < NUM_GENERAL; c++) begin
                  if (i_wb_adr == csd_pkg::ADDR_CH_BASE0 + 8'(4*c)) next_base[c] = wdata;
                  if (i_wb_adr == csd_pkg::ADDR_CH_OPTION0 + 8'(4*c)) next_option[c] = wdata;
               end
            end
         endcase
      end
      case (i_wb_adr)
         csd_pkg::ADDR_PIN_ASSIGN0: next_rdata = {20'h00000, pin_assignment_regs[11:0]};
         csd_pkg::ADDR_PIN_ASSIGN1: next_rdata = {20'h00000, pin_assignment_regs[23:12]};
         csd_pkg::ADDR_DISCRETE: next_rdata = {25'h0000000, discrete_output_latch};
         csd_pkg::ADDR_BOOT_BASE: next_rdata = {16'h0000, boot_base_reg};
         csd_pkg::ADDR_BOOT_OPTION: next_rdata = {16'h0000, boot_option_reg};
         csd_pkg::ADDR_STATUS: next_rdata = {20'h00000, match};
         default: begin
            for (int c = 0; c < NUM_GENERAL; c++) begin
               if (i_wb_adr == csd_pkg::ADDR_CH_BASE0 + 8'(4*c)) next_rdata = {16'h0000, channel_base_regs[c]};
               if (i_wb_adr == csd_pkg::ADDR_CH_OPTION0 + 8'(4*c)) next_rdata = {16'h0000, channel_option_regs[c]};
            end
         end
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pin_assignment_regs <= csd_pkg::PIN_ASSIGN_RESET;
         discrete_output_latch <= csd_pkg::DISCRETE_RESET;
         boot_base_reg <= csd_pkg::BOOT_BASE_RESET;
         boot_option_reg <= csd_pkg::BOOT_OPTION_RESET;
         for (int c = 0; c < NUM_GENERAL; c++) begin
            channel_base_regs[c] <= csd_pkg::CH_BASE_RESET;
            channel_option_regs[c] <= csd_pkg::CH_OPTION_RESET;
         end
         strap_pending <= 1'b1;
         ack <= 1'b0;
         o_wb_dat <= 32'h00000000;
      end else begin
         pin_assignment_regs <= next_pin;
         discrete_output_latch <= next_discrete;
         boot_base_reg <= next_boot_base;
         boot_option_reg <= next_boot_option;
         channel_base_regs <= next_base;
         channel_option_regs <= next_option;
         strap_pending <= 1'b0;
         ack <= next_ack;
         o_wb_dat <= next_rdata;
      end
   end
   assign o_wb_ack = ack;

   // ****************************************
   // Channel compare
   // ****************************************
   always_comb begin
      bas[0] = boot_base_reg;
      opt[0] = boot_option_reg;
      for (int c = 0; c < NUM_GENERAL; c++) begin
         bas[c+1] = channel_base_regs[c];
         opt[c+1] = channel_option_regs[c];
      end
   end

   // Index 0 is the boot channel, index c+1 is general channel c
   for (genvar g = 0; g < NCH; g++) begin : g_ch
      csd_channel csd_channel_i (
         .i_base(bas[g]),
         .i_option(opt[g]),
         .i_wide_port(pin_assignment_regs[2*g+1] ? pin_assignment_regs[2*g] : 1'b1),
         .i_addr(i_addr),
         .i_fc(i_fc),
         .i_read(i_read),
         .i_siz(i_transfer_size_lines),
         .o_match(match[g])
      );
   end

   // ****************************************
   // Select, pin and termination outputs
   // ****************************************
   always_comb begin
      next_sel = '0;
      next_pin_val = '1;
      next_ack_out = 1'b0;
      next_autovector_request = 1'b0;
      o_pin_is_alternate = '0;
      for (int c = 0; c < NCH; c++) begin
         logic strobe_ok;
         logic hit;
         strobe_ok = opt[c][csd_pkg::OPT_MODE_BIT] ? i_sync_bus_clock
                   : (opt[c][12] ? i_data_strobe : i_addr_strobe);
         hit = match[c] && i_addr_strobe && !i_internal_hit && strobe_ok;
         case (csd_pkg::csd_pin_type'(pin_assignment_regs[2*c +: 2]))
            csd_pkg::CSD_PIN_SELECT8, csd_pkg::CSD_PIN_SELECT16: next_sel[c] = hit;
            csd_pkg::CSD_PIN_ALTERNATE: o_pin_is_alternate[c] = 1'b1;
            csd_pkg::CSD_PIN_DISCRETE: begin
               if (c == NCH - 1) next_pin_val[c] = i_sync_bus_clock;
               else if (c >= 4) next_pin_val[c] = discrete_output_latch[c-4];
               else next_pin_val[c] = 1'b1;
            end
            default: next_sel[c] = 1'b0;
         endcase
         if (c == 0 && pin_assignment_regs[1:0] == 2'h0) next_sel[c] = hit;
         if (hit && !opt[c][csd_pkg::OPT_MODE_BIT]) begin
            if (opt[c][csd_pkg::OPT_SIZE_ACK_LSB +: 4] != csd_pkg::SIZE_ACK_EXTERNAL) next_ack_out = 1'b1;
            if (opt[c][csd_pkg::OPT_AUTOVECTOR_REQUEST_BIT] && i_fc == csd_pkg::FC_CPU_SPACE) next_autovector_request = 1'b1;
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         sel_q <= '0;
         pin_q <= '1;
         ack_q <= 1'b0;
         autovector_request_q <= 1'b0;
      end else begin
         sel_q <= next_sel;
         pin_q <= next_pin_val;
         ack_q <= next_ack_out;
         autovector_request_q <= next_autovector_request;
      end
   end

   assign o_select_n = ~sel_q;
   assign o_pin_value = pin_q;
   assign o_size_ack_n = ~ack_q;
   assign o_autovector_request_n = ~autovector_request_q;
   assign o_ext_bus_enable = !i_internal_hit;

   // ****************************************
   // Checks
   // ****************************************
   property p_internal;
      @(posedge i_core_clk) disable iff (!i_resetn) i_internal_hit |=> &o_select_n;
   endproperty
   a_internal: assert property (p_internal) else $error("select during internal access");

   property p_nomatch;
      @(posedge i_core_clk) disable iff (!i_resetn) !match[1] |=> o_select_n[1];
   endproperty
   a_nomatch: assert property (p_nomatch) else $error("select without match");

   property p_cycle_end;
      @(posedge i_core_clk) disable iff (!i_resetn) !i_addr_strobe |=> (&o_select_n && o_size_ack_n);
   endproperty
   a_cycle_end: assert property (p_cycle_end) else $error("select held after cycle");

   property p_disabled;
      @(posedge i_core_clk) disable iff (!i_resetn)
         (channel_option_regs[0][14:13] == 2'h0) |=> o_select_n[1];
   endproperty
   a_disabled: assert property (p_disabled) else $error("disabled channel selected");

   property p_boot_byte;
      @(posedge i_core_clk) disable iff (!i_resetn) $rose(strap_pending == 1'b0) |-> boot_option_reg[14:13] == 2'h3;
   endproperty
   a_boot_byte: assert property (p_boot_byte) else $error("boot byte field not set");

   property p_boot_width;
      @(posedge i_core_clk) disable iff (!i_resetn)
         $fell(strap_pending) |-> pin_assignment_regs[1:0] == ($past(i_strap_data[0]) ? 2'h3 : 2'h2);
   endproperty
   a_boot_width: assert property (p_boot_width) else $error("boot width strap wrong");

   property p_discrete;
      @(posedge i_core_clk) disable iff (!i_resetn)
         (i_resetn && pin_assignment_regs[9:8] == 2'h0) |=> o_pin_value[4] == $past(discrete_output_latch[0]);
   endproperty
   a_discrete: assert property (p_discrete) else $error("discrete bit not driven");

   property p_reserved;
      @(posedge i_core_clk) disable iff (!i_resetn)
         (pin_assignment_regs[3:2] == 2'h0) |=> (o_pin_value[1] && o_select_n[1]);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved code drove pin");
endmodule // csd_decoder

// file: bench/csd_ext_bus_model.sv
// External memories and peripherals that sit behind the chip selects
`timescale 1ns/1ps
module csd_ext_bus_model #(
   parameter logic [7:0] STRAP_LOW = 8'h5A
) (
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic [11:0] i_select_n,
   output logic [7:0] o_strap_data,
   output logic [11:0] o_seen
);
   // Weak pull-ups keep data lines high unless a device holds them low
   assign o_strap_data = ~STRAP_LOW;
   // Each device notes that its select went low at least once
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_seen <= 12'h000;
      end else begin
         o_seen <= o_seen | ~i_select_n;
      end
   end
endmodule // csd_ext_bus_model

// file: bench/csd_decoder_test.sv
// Self-checking testbench for the chip-select decoder
`timescale 1ns/1ps
module csd_decoder_test;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h00000000;
   logic [31:0] rdat;
   logic ack, ext_en, sack_n, autovector_request_n;
   logic [7:0] strap;
   logic [23:0] addr = 24'h000000;
   logic [2:0] fc = 3'h5;
   logic rd = 1'b1;
   logic [1:0] transfer_size_lines = 2'h1;
   logic as = 1'b0, ds = 1'b0, sync_bus_clock = 1'b0, hit = 1'b0;
   logic [11:0] sel_n, pin_val, pin_alt, seen;
   int bad_count = 0;
   int checks = 0;
   localparam logic [23:0] BLK [0:7] = '{24'h000800, 24'h002000, 24'h004000, 24'h010000,
      24'h020000, 24'h040000, 24'h080000, 24'h100000};
   always #2 clk = ~clk;
   csd_decoder csd_decoder_i (.i_core_clk(clk), .i_resetn(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
      .i_wb_adr(adr), .i_wb_sel(4'h3), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_strap_data(strap),
      .i_addr(addr), .i_fc(fc), .i_read(rd), .i_transfer_size_lines(transfer_size_lines), .i_addr_strobe(as), .i_data_strobe(ds),
      .i_sync_bus_clock(sync_bus_clock), .i_internal_hit(hit), .o_ext_bus_enable(ext_en), .o_select_n(sel_n),
      .o_pin_value(pin_val), .o_pin_is_alternate(pin_alt), .o_size_ack_n(sack_n), .o_autovector_request_n(autovector_request_n));
   csd_ext_bus_model csd_ext_bus_model_i (.i_core_clk(clk), .i_resetn(rst_n), .i_select_n(sel_n),
      .o_strap_data(strap), .o_seen(seen));
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic chk(input string name, input logic [31:0] seen_v, input logic [31:0] exp_v);
      checks++;
      if (seen_v !== exp_v) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp_v, seen_v);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {16'h0000, d};
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      chk("wb_ack", 32'(ack), 32'h00000001);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 16'h0000, q);
      chk($sformatf("reg_%h", a), q, e);
   endtask
   // One strobed bus access; ack flags gather over the held cycles
   task automatic acc(input logic [23:0] a, input logic [2:0] f, input logic r, input logic [1:0] s,
      input logic h, input logic [11:0] e, output logic sa, output logic av);
      @(posedge clk);
      addr <= a;
      fc <= f;
      rd <= r;
      transfer_size_lines <= s;
      hit <= h;
      as <= 1'b1;
      ds <= 1'b1;
      sa = 1'b0;
      av = 1'b0;
      repeat (3) begin
         @(posedge clk);
         #1;
         sa = sa | (sack_n === 1'b0);
         av = av | (autovector_request_n === 1'b0);
      end
      chk("select_n", 32'(sel_n), 32'(e));
      chk("ext_bus_enable", 32'(ext_en), 32'(!h));
      @(posedge clk);
      as <= 1'b0;
      ds <= 1'b0;
      @(posedge clk);
      #1;
      chk("select_n_end", 32'(sel_n), 32'h00000FFF);
   endtask
   task automatic close_out();
      $display("Checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      chk("select_n", 32'(sel_n), 32'h00000FFF);
      chk("pin_alt", 32'(pin_alt), 32'h000002F2);
      chk("pin_value", 32'(pin_val), 32'h00000FFF);
      chk("acks_n", {30'h0, sack_n, autovector_request_n}, 32'h00000003);
      rc(8'h0C, 32'h00000006);
      rc(8'h10, 32'h00006830);
      rc(8'h00, 32'h000005F7);
      rc(8'h04, 32'h00000F75);
      rc(8'h08, 32'h00000000);
      rc(8'h40, 32'h00000000);
      rc(8'hA8, 32'h00000000);
      wr(8'hFC, 16'hFFFF);
      rc(8'hFC, 32'h00000000);
   endtask
   task automatic t_boot();
      logic sa, av;
      acc(24'h000010, 3'h5, 1'b1, 2'h1, 1'b0, 12'hFFE, sa, av);
      chk("size_ack", 32'(sa), 32'h00000001);
      acc(24'h07FFFE, 3'h1, 1'b1, 2'h2, 1'b0, 12'hFFE, sa, av);
      acc(24'h080000, 3'h5, 1'b1, 2'h1, 1'b0, 12'hFFF, sa, av);
      acc(24'h000020, 3'h5, 1'b1, 2'h1, 1'b1, 12'hFFF, sa, av);
   endtask
   task automatic t_enable();
      logic sa, av;
      wr(8'h00, 16'h05FB);
      wr(8'h40, 16'h0007);
      wr(8'h80, 16'h1BF0);
      acc(24'h000010, 3'h5, 1'b1, 2'h1, 1'b0, 12'hFFE, sa, av);
      wr(8'h80, 16'h3BF0);
      acc(24'h000010, 3'h5, 1'b1, 2'h1, 1'b0, 12'hFFC, sa, av);
      wr(8'h80, 16'h2BF0);
      acc(24'h000010, 3'h5, 1'b0, 2'h1, 1'b0, 12'hFFF, sa, av);
      acc(24'h000010, 3'h5, 1'b1, 2'h1, 1'b0, 12'hFFC, sa, av);
   endtask
   task automatic t_block();
      logic sa, av;
      wr(8'h44, 16'h8000);
      wr(8'h84, 16'h7BF0);
      for (int k = 0; k < 8; k++) begin
         wr(8'h44, 16'h8000 | 16'(k));
         acc(24'h800000 + BLK[k] - 24'h000002, 3'h5, 1'b1, 2'h2, 1'b0, 12'hFFB, sa, av);
         acc(24'h800000 + BLK[k], 3'h5, 1'b1, 2'h2, 1'b0, 12'hFFF, sa, av);
      end
      wr(8'h84, 16'h3BF0);
      acc(24'h800010, 3'h5, 1'b1, 2'h1, 1'b0, 12'hFFF, sa, av);
      acc(24'h800011, 3'h5, 1'b1, 2'h1, 1'b0, 12'hFFB, sa, av);
   endtask
   task automatic t_iack();
      logic sa, av;
      wr(8'h48, 16'hFFFB);
      wr(8'h88, 16'h6BC7);
      acc(24'hFFFFF7, 3'h7, 1'b1, 2'h1, 1'b0, 12'hFF7, sa, av);
      chk("autovector", 32'(av), 32'h00000001);
      acc(24'hFFFFF9, 3'h7, 1'b1, 2'h1, 1'b0, 12'hFFF, sa, av);
      chk("autovector", 32'(av), 32'h00000000);
   endtask
   task automatic t_alt();
      logic sa, av;
      wr(8'h4C, 16'h2007);
      wr(8'h8C, 16'h7830);
      acc(24'h200000, 3'h5, 1'b1, 2'h1, 1'b0, 12'hFFF, sa, av);
      chk("size_ack", 32'(sa), 32'h00000001);
      chk("pin_alt", 32'(pin_alt), 32'h000002F0);
   endtask
   task automatic t_discrete();
      logic sa, av;
      wr(8'h08, 16'h0055);
      rc(8'h08, 32'h00000055);
      wr(8'h00, 16'h00A0);
      wr(8'h04, 16'h0000);
      @(posedge clk);
      sync_bus_clock <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk("pin_value", 32'(pin_val), 32'h00000D5F);
      chk("pin_alt", 32'(pin_alt), 32'h00000000);
      @(posedge clk);
      sync_bus_clock <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk("pin_value", 32'(pin_val), 32'h0000055F);
      acc(24'h000010, 3'h5, 1'b1, 2'h1, 1'b0, 12'hFFE, sa, av);
   endtask
   // Synchronous mode: select only while the bus clock is high
   task automatic t_sync();
      logic sa, av;
      wr(8'h84, 16'hBBF0);
      acc(24'h800011, 3'h5, 1'b1, 2'h1, 1'b0, 12'hFFF, sa, av);
      @(posedge clk);
      sync_bus_clock <= 1'b1;
      acc(24'h800011, 3'h5, 1'b1, 2'h1, 1'b0, 12'hFFB, sa, av);
      @(posedge clk);
      sync_bus_clock <= 1'b0;
   endtask
   // ****************************************
   // Main sequence and watchdog
   // ****************************************
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_boot();
      t_enable();
      t_block();
      t_iack();
      t_alt();
      t_discrete();
      t_sync();
      chk("far_side_seen", 32'(seen), 32'h0000000F);
      close_out();
   end
   initial begin
      #50000;
      bad_count++;
      close_out();
   end
endmodule // csd_decoder_test
